// [common/csg_params.svh]
`ifndef CSG_PARAMS_SVH
`define CSG_PARAMS_SVH

// ==========================================================================
// Register map
`define CSG_ADDR_W        12
`define CSG_CTRL_ADDR     12'h000
`define CSG_STAT_ADDR     12'h004

// ==========================================================================
// Control register fields and reset value
`define CSG_CTRL_ALIGN    0
`define CSG_CTRL_RST      32'h0000_0001

// ==========================================================================
// Status register fields
`define CSG_STAT_RATIO_LO 0
`define CSG_STAT_DELAY_LO 4
`define CSG_STAT_MODE_LO  7
`define CSG_STAT_LOCKED   9
`define CSG_STAT_BADRAT   10
`define CSG_STAT_OSCBAD   11

// ==========================================================================
// Strap limits and reset values
`define CSG_RATIO_MIN     4'h3
`define CSG_RATIO_RST     4'h3
`define CSG_DELAY_RST     3'h0
`define CSG_SYNC_W        13

`endif

// [common/csg_pkg.sv]
package csg_pkg;

	// ======================================================================
	// Core clock mode strap encodings
	typedef enum logic [1:0] {
		CSG_MODE_HALF    = 2'b00,
		CSG_MODE_FULL    = 2'b01,
		CSG_MODE_QUARTER = 2'b10,
		CSG_MODE_HOLD    = 2'b11
	} csg_mode_t;

	// ======================================================================
	// Edge slip aligner states
	typedef enum logic [1:0] {
		CSG_AL_OFF   = 2'b00,
		CSG_AL_SEEK  = 2'b01,
		CSG_AL_TRACK = 2'b10
	} csg_align_t;

endpackage

// [rtl/csg_apb.sv]
`include "csg_params.svh"

// ==========================================================================
// APB slave with control and status words
module csg_apb
	import csg_pkg::*;
(
	input  wire logic                   mclk_in,
	input  wire logic                   rst_n_in,
	input  wire logic [`CSG_ADDR_W-1:0] paddr_in,
	input  wire logic                   psel_in,
	input  wire logic                   penable_in,
	input  wire logic                   pwrite_in,
	input  wire logic [31:0]            pwdata_in,
	input  wire logic [31:0]            status_in,
	output logic      [31:0]            ctrl_out,
	output logic      [31:0]            prdata_out,
	output logic                        pready_out,
	output logic                        pslverr_out
);

	logic mapped;
	logic setup;
	logic access;

	assign mapped = (paddr_in == `CSG_CTRL_ADDR) ||
		(paddr_in == `CSG_STAT_ADDR);
	assign setup  = psel_in && !penable_in;
	assign access = psel_in && penable_in;

	// Zero wait states; unmapped addresses answer with an error
	assign pready_out  = 1'b1;
	assign pslverr_out = access && !mapped;

	// Control word written in the access phase
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_out <= `CSG_CTRL_RST;
		end else if (access && pwrite_in && paddr_in == `CSG_CTRL_ADDR) begin
			ctrl_out <= {31'h0000_0000, pwdata_in[`CSG_CTRL_ALIGN]};
		end
	end

	// Read data captured in the setup phase, held through access
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (setup) begin
			if (paddr_in == `CSG_CTRL_ADDR) begin
				prdata_out <= ctrl_out;
			end else if (paddr_in == `CSG_STAT_ADDR) begin
				prdata_out <= status_in;
			end else begin
				prdata_out <= 32'h0000_0000;
			end
		end
	end

endmodule

// [rtl/csg_sync.sv]
// ==========================================================================
// Two flip-flop synchroniser for pin levels
module csg_sync
	import csg_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end

endmodule

// [rtl/csg_top.sv]
// The register addresses and the APB slave port are this design's own decisions.
`include "csg_params.svh"

// Function
// - Core clock derived from differential oscillator pair
// - Mode 00 divides oscillator by two
// - Mode 01 passes oscillator rate undivided
// - Mode 10 divides oscillator by four
// - Mode 11 holds generator initialised
// - System clock is core divided by strap ratio
// - Ratio is interrupt straps as binary; straps below 3 give ratio 3
// - System signals launch on system clock rise
// - System period equals ratio times core period
// - Second system clock is delayed copy
// - Core clock presented on own pin
// - Reference clock may steer system clocks
// - Delay 0 to 7 from three straps
// - Odd divisor keeps clock high longer
// - Edge meeting stalls generator one oscillator period
module csg_top
	import csg_pkg::*;
(
	input  wire logic                   mclk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   osc_clk_p_in,
	input  wire logic                   osc_clk_n_in,
	input  wire logic [1:0]             clk_mode_in,
	input  wire logic                   ref_clk_in,
	input  wire logic                   sys_reset_n_in,
	input  wire logic [3:0]             irq_in,
	input  wire logic                   mch_hlt_irq_in,
	input  wire logic                   pwr_fail_irq_in,
	input  wire logic                   sys_mch_chk_irq_in,
	input  wire logic [`CSG_ADDR_W-1:0] paddr_in,
	input  wire logic                   psel_in,
	input  wire logic                   penable_in,
	input  wire logic                   pwrite_in,
	input  wire logic [31:0]            pwdata_in,
	output logic      [31:0]            prdata_out,
	output logic                        pready_out,
	output logic                        pslverr_out,
	output logic                        core_clk_out,
	output logic                        system_clock_output_p_out,
	output logic                        system_clock_output_n_out,
	output logic                        delayed_system_clock_output_p_out,
	output logic                        delayed_system_clock_output_n_out
);

	// ======================================================================
	// Pin synchronisation
	logic [`CSG_SYNC_W-1:0] raw_pins;
	logic [`CSG_SYNC_W-1:0] sync_pins;
	logic                   pwrup_rst;
	logic                   ref_s;
	logic                   osc_p_s;
	logic                   osc_n_s;
	csg_mode_t              mode_s;
	logic [3:0]             irq_s;
	logic [2:0]             delay_strap;
	logic [2:0]             boot;

	assign raw_pins = {sys_reset_n_in, ref_clk_in, osc_clk_n_in,
		osc_clk_p_in, clk_mode_in, irq_in, sys_mch_chk_irq_in,
		pwr_fail_irq_in, mch_hlt_irq_in};

	csg_sync #(
		.WIDTH(`CSG_SYNC_W)
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.d_in     (raw_pins),
		.q_out    (sync_pins)
	);

	// Pins count only once the synchroniser has flushed its reset value
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot <= 3'h0;
		end else begin
			boot <= {boot[1:0], 1'b1};
		end
	end

	assign pwrup_rst   = !sync_pins[12] || !boot[2];
	assign ref_s       = sync_pins[11];
	assign osc_n_s     = sync_pins[10];
	assign osc_p_s     = sync_pins[9];
	assign mode_s      = csg_mode_t'(sync_pins[8:7]);
	assign irq_s       = sync_pins[6:3];
	assign delay_strap = sync_pins[2:0]; // Machine check is msb

	// ======================================================================
	// Register bus
	logic [31:0] ctrl;
	logic [31:0] status;
	logic        align_en;
	logic        locked;
	logic        ratio_bad;
	logic [3:0]  ratio;
	logic [2:0]  delay;

	assign align_en = ctrl[`CSG_CTRL_ALIGN];
	assign status   = {20'h00000, !(osc_p_s ^ osc_n_s), ratio_bad, locked,
		mode_s, delay, ratio};

	csg_apb u_apb (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.paddr_in    (paddr_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.pwrite_in   (pwrite_in),
		.pwdata_in   (pwdata_in),
		.status_in   (status),
		.ctrl_out    (ctrl),
		.prdata_out  (prdata_out),
		.pready_out  (pready_out),
		.pslverr_out (pslverr_out)
	);

	// ======================================================================
	// Strap capture
	// Ratio and delay follow the straps only while power-up reset is asserted
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ratio     <= `CSG_RATIO_RST;
			delay     <= `CSG_DELAY_RST;
			ratio_bad <= 1'b0;
		end else if (pwrup_rst) begin
			delay <= delay_strap;
			if (irq_s < `CSG_RATIO_MIN) begin
				ratio     <= `CSG_RATIO_MIN;
				ratio_bad <= 1'b1;
			end else begin
				ratio     <= irq_s;
				ratio_bad <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Oscillator edge detection
	logic osc_q;
	logic osc_rise;
	logic osc_fall;
	logic stall_pend;
	logic advance;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= osc_p_s;
		end
	end

	// Only a true differential level counts as a rising edge; falls are not checked
	assign osc_rise = osc_p_s && !osc_q && (osc_p_s ^ osc_n_s);
	assign osc_fall = !osc_p_s && osc_q;
	assign advance  = osc_rise && !stall_pend;

	// ======================================================================
	// Core clock divider
	logic [1:0] div_cnt;
	logic       core_clk;
	logic       next_core;
	logic       core_tick;

	always_comb begin
		next_core = core_clk;
		case (mode_s)
			CSG_MODE_HALF: begin
				if (advance) next_core = !core_clk;
			end
			CSG_MODE_FULL: begin
				if (advance) begin
					next_core = 1'b1;
				end else if (osc_fall) begin
					next_core = 1'b0;
				end
			end
			CSG_MODE_QUARTER: begin
				if (advance && div_cnt[0]) next_core = !core_clk;
			end
			CSG_MODE_HOLD: begin
				next_core = 1'b0;
			end
			default: begin
				next_core = 1'b0;
			end
		endcase
	end

	assign core_tick = next_core && !core_clk;

	// Divider phase counter, cleared while held
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt <= 2'h0;
		end else if (mode_s == CSG_MODE_HOLD) begin
			div_cnt <= 2'h0;
		end else if (advance) begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	// Core clock level and its output pin
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_clk     <= 1'b0;
			core_clk_out <= 1'b0;
		end else begin
			core_clk     <= next_core;
			core_clk_out <= next_core;
		end
	end

	// ======================================================================
	// System clock divider
	logic       run;
	logic [3:0] sys_cnt;
	logic [3:0] next_sys_cnt;
	logic       sys_last;
	logic       sys_rise;
	logic [4:0] hi_sum;
	logic [3:0] hi_len;
	logic       next_sys;

	assign run      = (mode_s != CSG_MODE_HOLD) && !pwrup_rst;
	assign sys_last = sys_cnt >= (ratio - 4'h1);
	assign next_sys_cnt = sys_last ? 4'h0 : sys_cnt + 4'h1;
	// Odd ratios stay high for the extra core cycle
	assign hi_sum   = {1'b0, ratio} + 5'h01;
	assign hi_len   = hi_sum[4:1];
	assign next_sys = next_sys_cnt < hi_len;
	// System interface edge: the only launch and capture point
	assign sys_rise = run && core_tick && sys_last;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sys_cnt <= 4'h0;
		end else if (!run) begin
			sys_cnt <= ratio - 4'h1;
		end else if (core_tick) begin
			sys_cnt <= next_sys_cnt;
		end
	end

	// Differential system clock pair
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			system_clock_output_p_out <= 1'b0;
			system_clock_output_n_out <= 1'b1;
		end else if (!run) begin
			system_clock_output_p_out <= 1'b0;
			system_clock_output_n_out <= 1'b1;
		end else if (core_tick) begin
			system_clock_output_p_out <= next_sys;
			system_clock_output_n_out <= !next_sys;
		end
	end

	// ======================================================================
	// Delayed system clock
	logic [6:0] hist;
	logic [7:0] taps;

	assign taps = {hist, next_sys};

	// History of system clock levels, one entry per core period
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hist <= 7'h00;
		end else if (!run) begin
			hist <= 7'h00;
		end else if (core_tick) begin
			hist <= {hist[5:0], next_sys};
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			delayed_system_clock_output_p_out <= 1'b0;
			delayed_system_clock_output_n_out <= 1'b1;
		end else if (!run) begin
			delayed_system_clock_output_p_out <= 1'b0;
			delayed_system_clock_output_n_out <= 1'b1;
		end else if (core_tick) begin
			delayed_system_clock_output_p_out <= taps[delay];
			delayed_system_clock_output_n_out <= !taps[delay];
		end
	end

	// ======================================================================
	// Edge slip aligner
	csg_align_t al_state;
	logic       slip_req;

	// A low reference at a system rise means the edges have met
	assign slip_req = sys_rise && align_en && !ref_s;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			al_state <= CSG_AL_OFF;
			locked   <= 1'b0;
		end else if (!align_en || !run) begin
			al_state <= CSG_AL_OFF;
			locked   <= 1'b0;
		end else if (sys_rise) begin
			case (al_state)
				CSG_AL_OFF: begin
					al_state <= ref_s ? CSG_AL_SEEK : CSG_AL_TRACK;
				end
				CSG_AL_SEEK: begin
					if (!ref_s) begin
						al_state <= CSG_AL_TRACK;
						locked   <= 1'b1;
					end
				end
				CSG_AL_TRACK: begin
					if (ref_s) locked <= 1'b1;
				end
				default: begin
					al_state <= CSG_AL_OFF;
				end
			endcase
		end
	end

	// Stall swallows one oscillator edge; a new request wins
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stall_pend <= 1'b0;
		end else if (slip_req) begin
			stall_pend <= 1'b1;
		end else if (osc_rise) begin
			stall_pend <= 1'b0;
		end
	end

	// ======================================================================
	// Assertion helpers
	csg_mode_t  mode_q;
	logic       steady;
	logic [2:0] adv_cnt;
	logic [3:0] tick_cnt;
	logic       seen;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q  <= CSG_MODE_HOLD;
			steady  <= 1'b0;
			adv_cnt <= 3'h0;
		end else begin
			mode_q <= mode_s;
			if (mode_s != mode_q) begin
				steady  <= 1'b0;
				adv_cnt <= 3'h0;
			end else if (core_tick) begin
				steady  <= 1'b1;
				adv_cnt <= 3'h0;
			end else if (advance && adv_cnt != 3'h7) begin
				adv_cnt <= adv_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt <= 4'h0;
			seen     <= 1'b0;
		end else if (!run) begin
			tick_cnt <= 4'h0;
			seen     <= 1'b0;
		end else if (sys_rise) begin
			tick_cnt <= 4'h0;
			seen     <= 1'b1;
		end else if (core_tick && tick_cnt != 4'hF) begin
			tick_cnt <= tick_cnt + 4'h1;
		end
	end

	// ======================================================================
	// Assertions
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	core_from_osc_a: assert property (
		core_tick |-> osc_rise)
		else $error("core edge without oscillator edge");
	half_rate_a: assert property (
		core_tick && steady && mode_s == CSG_MODE_HALF |-> adv_cnt == 3'h1)
		else $error("half mode core period wrong");
	full_rate_a: assert property (
		core_tick && steady && mode_s == CSG_MODE_FULL |-> adv_cnt == 3'h0)
		else $error("full mode core period wrong");
	quarter_rate_a: assert property (
		core_tick && steady && mode_s == CSG_MODE_QUARTER
		|-> adv_cnt == 3'h3)
		else $error("quarter mode core period wrong");
	hold_init_a: assert property (
		mode_s == CSG_MODE_HOLD |=> !core_clk_out
		&& !system_clock_output_p_out)
		else $error("clocks run while held");
	ratio_map_a: assert property (
		pwrup_rst && irq_s >= `CSG_RATIO_MIN |=> ratio == $past(irq_s))
		else $error("ratio differs from straps");
	sys_period_a: assert property (
		sys_rise && seen |-> tick_cnt + 4'h1 == ratio)
		else $error("system period not ratio core periods");
	odd_high_a: assert property (
		$fell(system_clock_output_p_out) && run |-> sys_cnt == hi_len)
		else $error("system clock high time wrong");
	delay_copy_a: assert property (
		run && core_tick && delay == 3'h0 ##1 run
		|-> delayed_system_clock_output_p_out == system_clock_output_p_out)
		else $error("zero delay copy differs");
	slip_stall_a: assert property (
		slip_req |=> stall_pend ##[0:1000] (osc_rise && !advance))
		else $error("slip did not swallow an edge");
	strap_hold_a: assert property (
		!pwrup_rst |=> $stable(ratio) && $stable(delay))
		else $error("straps changed after reset");
	core_pin_a: assert property (
		core_tick |=> core_clk_out ##1 (core_clk_out || !core_tick))
		else $error("core pin missed core edge");
	align_gate_a: assert property (
		sys_rise |=> stall_pend == $past(align_en && !ref_s))
		else $error("slip does not follow reference level");

	lock_c: cover property (al_state == CSG_AL_TRACK && $rose(locked));
	slip_c: cover property (slip_req ##[1:200] osc_rise);
	quarter_c: cover property (mode_s == CSG_MODE_QUARTER && sys_rise);
	odd_c: cover property (ratio[0] && $fell(system_clock_output_p_out));

endmodule

// [testbench/csg_far_model.sv]
// ==========================================================================
// Board side model: oscillator, reference level and system-clocked logic
module csg_far_model
	import csg_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        sys_clk_in,
	input  wire logic        ref_high_in,
	output logic             osc_p_out,
	output logic             osc_n_out,
	output logic             ref_clk_out,
	output logic [15:0]      launch_cnt_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] osc_div;

	// Oscillator at one sixteenth of mclk, slow enough for the pin sync
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			osc_div   <= 3'h0;
			osc_p_out <= 1'b0;
		end else begin
			osc_div <= osc_div + 3'h1;
			if (osc_div == 3'h7) begin
				osc_p_out <= ~osc_p_out;
			end
		end
	end

	// Complement leg of the differential pair
	assign osc_n_out = ~osc_p_out;

	// Reference level as the bench asks; idle high like a tied-off pin
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ref_clk_out <= 1'b1;
		end else begin
			ref_clk_out <= ref_high_in;
		end
	end

	// Far logic launches its signals on the system clock rise only
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			launch_cnt_out <= 16'h0000;
		end else begin
			launch_cnt_out <= launch_cnt_out + 16'h0001;
		end
	end
endmodule

// [testbench/csg_top_tb.sv]
`include "csg_params.svh"

// ==========================================================================
// Self-checking bench for the clock generator
module csg_top_tb
	import csg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int OSC = 16;
	logic        mclk, rst_n, sys_reset_n, ref_high, psel, penable, pwrite;
	logic        osc_p, osc_n, ref_clk, pready, pslverr, core_clk;
	logic        sys_p, sys_n, dly_p, dly_n;
	logic [1:0]  clk_mode;
	logic [2:0]  dly_strap, prev_s, now_s;
	logic [3:0]  irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] launch;
	logic        er;
	int          fail_count, n_compared, cyc, per, hi, a, b;
	int          rises[3], falls[3], rise_at[3], fall_at[3];

	csg_top csg_top_i (.mclk_in(mclk), .rst_n_in(rst_n), .osc_clk_p_in(osc_p),
		.osc_clk_n_in(osc_n), .clk_mode_in(clk_mode), .ref_clk_in(ref_clk),
		.sys_reset_n_in(sys_reset_n), .irq_in(irq),
		.mch_hlt_irq_in(dly_strap[0]), .pwr_fail_irq_in(dly_strap[1]),
		.sys_mch_chk_irq_in(dly_strap[2]), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.core_clk_out(core_clk), .system_clock_output_p_out(sys_p),
		.system_clock_output_n_out(sys_n),
		.delayed_system_clock_output_p_out(dly_p),
		.delayed_system_clock_output_n_out(dly_n));

	csg_far_model csg_far_model_i (.mclk_in(mclk), .rst_n_in(rst_n),
		.sys_clk_in(sys_p), .ref_high_in(ref_high), .osc_p_out(osc_p),
		.osc_n_out(osc_n), .ref_clk_out(ref_clk), .launch_cnt_out(launch));

	// ======================================================================
	// Clock, edge monitor and hang guard
	always #20 mclk = ~mclk;

	// Watched clocks: delayed, system, core
	assign now_s = {dly_p, sys_p, core_clk};

	always @(posedge mclk) begin
		cyc++;
		for (int k = 0; k < 3; k++) begin
			if (now_s[k] === 1'b1 && prev_s[k] === 1'b0) begin
				rises[k]++;
				rise_at[k] = cyc;
			end
			if (now_s[k] === 1'b0 && prev_s[k] === 1'b1) begin
				falls[k]++;
				fall_at[k] = cyc;
			end
		end
		prev_s = now_s;
		if (cyc == 60000) begin
			fail_count++;
			stop_test();
		end
	end

	// ======================================================================
	// Shared tasks
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic c, input string m);
		n_compared++;
		if (c !== 1'b1) begin
			$display("wrong value at %0t: %s", $time, m);
			fail_count++;
		end
	endtask

	// Waits for the next rise (fall=0) or fall of a watched clock
	task automatic wait_edge(input int k, input bit fall);
		int c0, n;
		c0 = fall ? falls[k] : rises[k];
		n = 0;
		while ((fall ? falls[k] : rises[k]) == c0 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 2000) chk(1'b0, "clock edge missing");
	endtask

	task automatic measure(input int k);
		int r0;
		wait_edge(k, 0);
		r0 = rise_at[k];
		wait_edge(k, 1);
		hi = fall_at[k] - r0;
		wait_edge(k, 0);
		per = rise_at[k] - r0;
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] ad,
			input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Power-up reset with straps, then aligner enable
	task automatic power_up(input logic [1:0] m, input logic [3:0] r,
			input logic [2:0] d, input logic al);
		@(posedge mclk);
		clk_mode <= m;
		irq <= r;
		dly_strap <= d;
		sys_reset_n <= 1'b0;
		repeat (6) @(posedge mclk);
		chk(sys_p === 1'b0 && sys_n === 1'b1 && dly_p === 1'b0, "held");
		sys_reset_n <= 1'b1;
		apb(1'b1, `CSG_CTRL_ADDR, {31'h0, al});
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_apb();
		logic [31:0] st;
		apb(1'b0, `CSG_CTRL_ADDR, 32'h0);
		chk(rd === `CSG_CTRL_RST && er === 1'b0, "ctrl reset");
		apb(1'b1, `CSG_CTRL_ADDR, 32'h0);
		apb(1'b0, `CSG_CTRL_ADDR, 32'h0);
		chk(rd === 32'h0000_0000, "ctrl write");
		apb(1'b0, `CSG_STAT_ADDR, 32'h0);
		st = rd;
		apb(1'b1, `CSG_STAT_ADDR, 32'hFFFF_FFFF);
		apb(1'b0, `CSG_STAT_ADDR, 32'h0);
		chk(rd === st, "status written");
		apb(1'b0, 12'h008, 32'h0);
		chk(er === 1'b1 && rd === 32'h0, "unmapped read");
		apb(1'b1, 12'h008, 32'h0);
		chk(er === 1'b1, "unmapped write");
	endtask

	task automatic t_modes();
		int dv[3] = '{2, 1, 4};
		for (int m = 0; m < 3; m++) begin
			power_up(m[1:0], 4'h3, 3'h0, 1'b0);
			measure(0);
			chk(per == OSC * dv[m], "core period");
		end
		power_up(2'h3, 4'h3, 3'h0, 1'b0);
		a = rises[0] + rises[1];
		repeat (300) @(negedge mclk);
		chk(rises[0] + rises[1] == a, "hold mode ran");
		apb(1'b0, `CSG_STAT_ADDR, 32'h0);
		chk(rd[8:7] === 2'h3, "mode field");
	endtask

	task automatic t_ratio();
		int rt[5] = '{3, 4, 5, 8, 15};
		for (int i = 0; i < 5; i++) begin
			power_up(2'h1, rt[i][3:0], 3'h0, 1'b0);
			apb(1'b0, `CSG_STAT_ADDR, 32'h0);
			chk(rd[3:0] === rt[i][3:0] && rd[10] === 1'b0, "ratio");
			wait_edge(1, 0);
			a = launch;
			b = rises[1];
			measure(1);
			chk(per == rt[i] * OSC, "sys period");
			chk(hi == (rt[i] + 1) / 2 * OSC, "sys high");
			chk(sys_n === ~sys_p, "pair");
			chk(launch - a == rises[1] - b, "launch");
		end
	endtask

	task automatic t_delay();
		for (int d = 0; d < 8; d++) begin
			power_up(2'h1, 4'h9, d[2:0], 1'b0);
			apb(1'b0, `CSG_STAT_ADDR, 32'h0);
			chk(rd[6:4] === d[2:0], "delay field");
			wait_edge(1, 0);
			wait_edge(1, 0);
			if (rise_at[2] != rise_at[1]) wait_edge(2, 0);
			chk(rise_at[2] - rise_at[1] == d * OSC, "delay");
			chk(dly_n === ~dly_p, "delayed pair");
		end
	endtask

	task automatic t_bad();
		for (int r = 0; r < 3; r++) begin
			power_up(2'h1, r[3:0], 3'h0, 1'b0);
			apb(1'b0, `CSG_STAT_ADDR, 32'h0);
			chk(rd[10] === 1'b1 && rd[3:0] === 4'h3, "bad ratio");
			@(posedge mclk);
			irq <= 4'hF;
			measure(1);
			chk(per == 3 * OSC, "strap relatched");
		end
	endtask

	task automatic t_align();
		@(posedge mclk);
		ref_high <= 1'b0;
		power_up(2'h0, 4'h4, 3'h0, 1'b1);
		wait_edge(1, 0);
		measure(1);
		chk(per == 4 * 2 * OSC + OSC, "slip stretch");
		@(posedge mclk);
		ref_high <= 1'b1;
		wait_edge(1, 0);
		wait_edge(1, 0);
		measure(1);
		chk(per == 4 * 2 * OSC, "slip after lock");
		apb(1'b0, `CSG_STAT_ADDR, 32'h0);
		chk(rd[9] === 1'b1, "not locked");
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		sys_reset_n = 1'b1;
		ref_high = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		clk_mode = 2'h1;
		irq = 4'h3;
		dly_strap = 3'h0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_apb();
		t_modes();
		t_ratio();
		t_delay();
		t_bad();
		t_align();
		stop_test();
	end
endmodule
